// ===== reset_irq_vector_mapper_tb.sv
`timescale 1ns/1ps
`default_nettype none

module reset_irq_vector_mapper_tb;
  localparam logic [11:0] BOOT = 12'hC00;
  logic                  clk, rst, bootResetFuse, vectorSelectBit;
  logic                  intEnable, takeEn, blind, takeIrq, clkEn;
  logic                  coreRun, resetFetch, bootFuseProgrammed;
  logic                  irqPending, fetchStrobe;
  logic [3:0]            latency;
  logic [11:0]           resetAddr, irqVector, fetchAddr;
  logic [4:0]            irqNumber;
  rivm_pkg::rivm_cause_s resetCause;
  rivm_pkg::rivm_req_s   irqReq;
  int                    mismatches, cmp_count, cycles, n;

  rivm_mapper #(.BOOT_START(BOOT)) rivm_mapper_inst (
    .clk(clk), .rst(rst), .clkEn(clkEn), .resetCause(resetCause),
    .bootResetFuse(bootResetFuse), .vectorSelectBit(vectorSelectBit),
    .intEnable(intEnable), .takeIrq(takeIrq), .irqReq(irqReq),
    .coreRun(coreRun), .resetFetch(resetFetch), .resetAddr(resetAddr),
    .bootFuseProgrammed(bootFuseProgrammed), .irqPending(irqPending),
    .irqVector(irqVector), .irqNumber(irqNumber),
    .fetchStrobe(fetchStrobe), .fetchAddr(fetchAddr));

  rivm_core_model rivm_core_model_inst (
    .clk(clk), .rst(rst), .takeEn(takeEn), .blind(blind),
    .latency(latency), .coreRun(coreRun), .irqPending(irqPending),
    .fetchStrobe(fetchStrobe), .takeIrq(takeIrq));

  always #5 clk = ~clk;

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // Returns slot address and vector number of the winner
  function automatic logic [16:0] expVec(input logic [24:0] r,
                                         input logic vs);
    for (int i = 0; i < 25; i++)
      if (r[i]) return {(vs ? BOOT : 12'h000) + 12'(i + 1), 5'(i + 2)};
    return 17'h0;
  endfunction

  task automatic waitLaunch(input logic fuse);
    int k;
    k = 0;
    while (resetFetch !== 1'b1 && k < 20) begin
      tick();
      k++;
    end
    check({11'h0, resetFetch}, 12'h001);
    check(resetAddr, fuse ? 12'h000 : BOOT);
    check({11'h0, coreRun}, 12'h001);
    check({11'h0, bootFuseProgrammed}, {11'h0, ~fuse});
    tick();
    check({11'h0, resetFetch}, 12'h000);
  endtask

  task automatic vecCheck(input logic [24:0] r, input logic vs,
                          input logic ie);
    logic [16:0] e;
    irqReq = rivm_pkg::rivm_req_s'(r);
    vectorSelectBit = vs;
    intEnable = ie;
    e = expVec(r, vs);
    tick();
    check({11'h0, irqPending}, {11'h0, (|r) & ie});
    if (|r) begin
      check(irqVector, e[16:5]);
      check({7'h0, irqNumber}, {7'h0, e[4:0]});
    end
  endtask

  task automatic takeCheck(input int k, input logic [3:0] lat);
    int w;
    vecCheck(25'(1) << k, k[0], 1'b1);
    latency = lat;
    takeEn = 1'b1;
    w = 0;
    while (fetchStrobe !== 1'b1 && w < 30) begin
      tick();
      w++;
    end
    check({11'h0, fetchStrobe}, 12'h001);
    check(fetchAddr, (k[0] ? BOOT : 12'h000) + 12'(k + 1));
    takeEn = 1'b0;
    tick();
    check({11'h0, fetchStrobe}, 12'h000);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    clkEn = 1'b1;
    bootResetFuse = 1'b1;
    vectorSelectBit = 1'b0;
    intEnable = 1'b0;
    takeEn = 1'b0;
    blind = 1'b0;
    latency = 4'h0;
    resetCause = '0;
    irqReq = '0;
    mismatches = 0;
    cmp_count = 0;
    cycles = 0;
    void'($urandom(66780));
    for (int f = 1; f >= 0; f--) begin
      bootResetFuse = f[0];
      rst = 1'b1;
      repeat (3) tick();
      rst = 1'b0;
      tick();
      check({11'h0, coreRun}, 12'h000);
      waitLaunch(f[0]);
    end
    $display("Test reset fuse done");
    // Fuse moves with the cause, since it is only sampled at launch
    for (int i = 0; i < 4; i++) begin
      bootResetFuse = i[0];
      resetCause = rivm_pkg::rivm_cause_s'(4'h1 << i);
      repeat (4) tick();
      check({11'h0, coreRun}, 12'h000);
      resetCause = '0;
      waitLaunch(i[0]);
    end
    $display("Test reset causes done");
    for (int vs = 0; vs < 2; vs++)
      for (int k = 0; k < 25; k++) vecCheck(25'(1) << k, vs[0], 1'b1);
    $display("Test vector table done");
    // Low clock enable must freeze the presented vector
    vecCheck(25'h1, 1'b0, 1'b1);
    clkEn = 1'b0;
    irqReq = rivm_pkg::rivm_req_s'(25'h2);
    repeat (2) tick();
    check(irqVector, 12'h001);
    clkEn = 1'b1;
    tick();
    check(irqVector, 12'h002);
    $display("Test clock enable done");
    vecCheck(25'h1FFFFFF, 1'b1, 1'b1);
    vecCheck(25'h1000000, 1'b0, 1'b1);
    repeat (60) vecCheck(25'($urandom) << ($urandom % 25),
                         1'($urandom), 1'($urandom));
    $display("Test priority done");
    for (int j = 0; j < 4; j++)
      takeCheck(j == 0 ? 0 : j == 1 ? 24 : $urandom % 25, 4'(j * 2));
    $display("Test take done");
    vecCheck(25'h8, 1'b0, 1'b0);
    blind = 1'b1;
    latency = 4'h0;
    takeEn = 1'b1;
    n = 0;
    repeat (10) begin
      tick();
      if (fetchStrobe !== 1'b0) n++;
    end
    check(12'(n), 12'h000);
    blind = 1'b0;
    takeEn = 1'b0;
    $display("Test refused take done");
    final_report();
  end
endmodule

`default_nettype wire

// ===== rivm_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module rivm_core_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Bench control
  input  wire logic       takeEn,
  input  wire logic       blind,
  input  wire logic [3:0] latency,
  // Mapper side
  input  wire logic       coreRun,
  input  wire logic       irqPending,
  input  wire logic       fetchStrobe,
  output logic            takeIrq
);
  logic [3:0] waitCnt;

  // Blind mode takes without a pending vector, to provoke a refusal
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      takeIrq <= #1 1'b0;
      waitCnt <= #1 4'h0;
    end else if (fetchStrobe || !takeEn || !coreRun) begin
      takeIrq <= #1 1'b0;
      waitCnt <= #1 4'h0;
    end else if (irqPending || blind) begin
      if (waitCnt >= latency) begin
        takeIrq <= #1 1'b1;
      end else begin
        waitCnt <= #1 waitCnt + 4'h1;
      end
    end
  end
endmodule

`default_nettype wire

// ===== rivm_mapper.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R01: Any reset cause with fuse unprogrammed restarts at address 0x0000.
// R02: With fuse programmed, every reset restarts at the boot reset address.
// R03: Vector-select set adds boot section start to each table address.
// R04: Select clear puts table at 0x001; unprogrammed fuse resets at 0x000.
// R05: Vector-select set puts table one word above boot reset address.
// R06: Fuse level one means unprogrammed, zero means programmed.
// R07: External request zero uses slot 0x0001, request one slot 0x0002.
// R08: Pin-change requests use 0x0003 to 0x0005, watchdog time-out 0x0006.
// R09: Counter 2 match A, match B, overflow use 0x0007 to 0x0009.
// R10: Counter 1 capture 0x000A, matches next two slots, overflow 0x000D.
// R11: Counter 0 match A, match B, overflow use 0x000E to 0x0010.
// R12: Serial transfer done uses 0x0011, conversion done uses 0x0015.
// R13: Async receive, transmit empty, transmit done use 0x0012 to 0x0014.
// R14: Data memory 0x0016, comparator 0x0017, two-wire 0x0018, store 0x0019.
// R15: A vector is fetched only when its interrupt is actually taken.
// R16: Among pending enabled requests the lowest vector number wins.
module rivm_mapper #(
  parameter logic [11:0] BOOT_START = rivm_pkg::BOOT_START_DEF
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                clkEn,
  // Reset causes and boot fuse, asynchronous pins
  input  wire rivm_pkg::rivm_cause_s resetCause,
  input  wire logic                bootResetFuse,
  // Control from the core side
  input  wire logic                vectorSelectBit,
  input  wire logic                intEnable,
  input  wire logic                takeIrq,
  // Peripheral request lines
  input  wire rivm_pkg::rivm_req_s irqReq,
  // Reset fetch
  output logic                     coreRun,
  output logic                     resetFetch,
  output logic [11:0]              resetAddr,
  output logic                     bootFuseProgrammed,
  // Interrupt vector
  output logic                     irqPending,
  output logic [11:0]              irqVector,
  output logic [4:0]               irqNumber,
  output logic                     fetchStrobe,
  output logic [11:0]              fetchAddr
);

  rivm_pkg::rivm_regs_s r;
  rivm_pkg::rivm_regs_s next_r;

  logic [rivm_pkg::NUM_SRC-1:0] reqBits;
  logic                         encFound;
  logic [rivm_pkg::IDX_W-1:0]   encIdx;
  logic [11:0]                  tableBase;

  assign reqBits = irqReq;

  rivm_prio_enc #(
    .N  (rivm_pkg::NUM_SRC),
    .IW (rivm_pkg::IDX_W)
  ) u_prio (
    .req   (reqBits),
    .found (encFound),
    .idx   (encIdx)
  );

  // Table moves with the select bit only, never with the fuse
  assign tableBase = vectorSelectBit ? BOOT_START
                                     : rivm_pkg::APP_BASE; // see R03 R04 R05

  always_comb begin
    next_r             = r;
    next_r.causeMeta   = resetCause;
    next_r.causeSync   = r.causeMeta;
    next_r.fuseMeta    = bootResetFuse;
    next_r.fuseSync    = r.fuseMeta;
    next_r.resetFetch  = 1'b0;
    next_r.fetchStrobe = 1'b0;

    // Slot order follows source order; lowest index wins
    next_r.irqPending = encFound & intEnable; // see R16
    next_r.irqVector  = tableBase + rivm_pkg::TABLE_OFS
                        + 12'(encIdx); // see R07 R08 R09 R10 R11
    next_r.irqNumber  = 5'(rivm_pkg::FIRST_VEC_NUM
                           + encIdx); // see R12 R13 R14

    case (r.st)
      rivm_pkg::ST_HOLD: begin
        next_r.coreRun = 1'b0;
        // Wait for the fuse synchroniser to fill after release
        if (r.holdCnt != rivm_pkg::HOLD_SETTLE) begin
          next_r.holdCnt = r.holdCnt + 2'h1;
        end else begin
          next_r.fuseProg = (r.fuseSync ==
                             rivm_pkg::FUSE_PROGRAMMED); // see R06
          next_r.st       = rivm_pkg::ST_LAUNCH;
        end
      end
      rivm_pkg::ST_LAUNCH: begin
        next_r.resetAddr  = r.fuseProg ? BOOT_START
                                       : rivm_pkg::RESET_ADDR; // see R01 R02
        next_r.resetFetch = 1'b1;
        next_r.coreRun    = 1'b1;
        next_r.st         = rivm_pkg::ST_RUN;
      end
      rivm_pkg::ST_RUN: begin
        // Only a taken interrupt reads its slot
        if (takeIrq && r.irqPending) begin
          next_r.fetchStrobe = 1'b1; // see R15
          next_r.fetchAddr   = r.irqVector;
          next_r.st          = rivm_pkg::ST_TAKEN;
        end
      end
      rivm_pkg::ST_TAKEN: begin
        // Gap lets the serviced source drop its line
        next_r.st = rivm_pkg::ST_RUN;
      end
      default: begin
        next_r.st = rivm_pkg::ST_HOLD;
      end
    endcase

    // Every cause holds the core and restarts the launch
    if (|r.causeSync) begin
      next_r.st      = rivm_pkg::ST_HOLD; // see R01
      next_r.holdCnt = 2'h0;
      next_r.coreRun = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else if (clkEn) begin
      r <= next_r;
    end
  end

  assign coreRun            = r.coreRun;
  assign resetFetch         = r.resetFetch;
  assign resetAddr          = r.resetAddr;
  assign bootFuseProgrammed = r.fuseProg;
  assign irqPending         = r.irqPending;
  assign irqVector          = r.irqVector;
  assign irqNumber          = r.irqNumber;
  assign fetchStrobe        = r.fetchStrobe;
  assign fetchAddr          = r.fetchAddr;

  a_reset_app_addr: assert property ( // see R01
    @(posedge clk) disable iff (rst)
    clkEn && r.st == rivm_pkg::ST_LAUNCH && !r.fuseProg
    |=> resetFetch && resetAddr == rivm_pkg::RESET_ADDR)
    else $error("Reset address not zero with fuse unprogrammed");

  a_reset_boot_addr: assert property ( // see R02
    @(posedge clk) disable iff (rst)
    clkEn && r.st == rivm_pkg::ST_LAUNCH && r.fuseProg
    |=> resetFetch && resetAddr == BOOT_START)
    else $error("Reset address not boot start with fuse programmed");

  a_boot_table: assert property ( // see R03
    @(posedge clk) disable iff (rst)
    clkEn && vectorSelectBit && intEnable && reqBits[3]
    && !(|reqBits[2:0])
    |=> irqVector == BOOT_START + rivm_pkg::TABLE_OFS + 12'h003)
    else $error("Boot table slot not offset by boot start");

  a_app_table: assert property ( // see R04
    @(posedge clk) disable iff (rst)
    clkEn && !vectorSelectBit && intEnable && reqBits[0]
    |=> irqPending && irqVector == rivm_pkg::TABLE_OFS)
    else $error("Application table does not start at one");

  a_boot_base: assert property ( // see R05
    @(posedge clk) disable iff (rst)
    clkEn && vectorSelectBit && intEnable && reqBits[0]
    |=> irqVector == BOOT_START + rivm_pkg::TABLE_OFS)
    else $error("Boot table does not start above boot reset");

  a_fuse_polarity: assert property ( // see R06
    @(posedge clk) disable iff (rst)
    clkEn && r.st == rivm_pkg::ST_HOLD && !(|r.causeSync)
    && r.holdCnt == rivm_pkg::HOLD_SETTLE
    |=> bootFuseProgrammed == !$past(r.fuseSync))
    else $error("Fuse level read with wrong polarity");

  a_ext_one_slot: assert property ( // see R07
    @(posedge clk) disable iff (rst)
    clkEn && !vectorSelectBit && intEnable && reqBits[1:0] == 2'h2
    |=> irqVector == rivm_pkg::SLOT_EXT_ONE)
    else $error("External request one slot wrong");

  a_watchdog_slot: assert property ( // see R08
    @(posedge clk) disable iff (rst)
    clkEn && !vectorSelectBit && intEnable && reqBits[5:0] == 6'h20
    |=> irqVector == rivm_pkg::SLOT_WATCHDOG)
    else $error("Watchdog slot wrong");

  a_cnt2_slot: assert property ( // see R09
    @(posedge clk) disable iff (rst)
    clkEn && !vectorSelectBit && intEnable && reqBits[8:0] == 9'h100
    |=> irqVector == rivm_pkg::SLOT_CNT2_OVF)
    else $error("Counter 2 overflow slot wrong");

  a_cnt1_slot: assert property ( // see R10
    @(posedge clk) disable iff (rst)
    clkEn && !vectorSelectBit && intEnable
    && reqBits[12:0] == 13'h1000
    |=> irqVector == rivm_pkg::SLOT_CNT1_OVF)
    else $error("Counter 1 overflow slot wrong");

  a_cnt0_slot: assert property ( // see R11
    @(posedge clk) disable iff (rst)
    clkEn && !vectorSelectBit && intEnable
    && reqBits[15:0] == 16'h8000
    |=> irqVector == rivm_pkg::SLOT_CNT0_OVF)
    else $error("Counter 0 overflow slot wrong");

  a_conv_slot: assert property ( // see R12
    @(posedge clk) disable iff (rst)
    clkEn && !vectorSelectBit && intEnable
    && reqBits[20:0] == 21'h100000
    |=> irqVector == rivm_pkg::SLOT_CONV_DONE && irqNumber == 5'h16)
    else $error("Conversion done slot wrong");

  a_async_slot: assert property ( // see R13
    @(posedge clk) disable iff (rst)
    clkEn && !vectorSelectBit && intEnable
    && reqBits[19:0] == 20'h80000
    |=> irqVector == rivm_pkg::SLOT_ASYNC_TXC)
    else $error("Async transmit done slot wrong");

  a_store_slot: assert property ( // see R14
    @(posedge clk) disable iff (rst)
    clkEn && !vectorSelectBit && intEnable
    && reqBits == 25'h1000000
    |=> irqVector == rivm_pkg::SLOT_STORE_RDY)
    else $error("Store program ready slot wrong");

  a_ext_zero_slot: assert property ( // see R07
    @(posedge clk) disable iff (rst)
    clkEn && !vectorSelectBit && intEnable && reqBits[0]
    |=> irqVector == rivm_pkg::SLOT_EXT_ZERO
        && irqNumber == rivm_pkg::FIRST_VEC_NUM)
    else $error("External request zero slot wrong");

  a_pin_c_slot: assert property ( // see R08
    @(posedge clk) disable iff (rst)
    clkEn && !vectorSelectBit && intEnable && reqBits[4:0] == 5'h10
    |=> irqVector == rivm_pkg::SLOT_PIN_C)
    else $error("Pin change C slot wrong");

  a_cnt1_capt_slot: assert property ( // see R10
    @(posedge clk) disable iff (rst)
    clkEn && !vectorSelectBit && intEnable && reqBits[9:0] == 10'h200
    |=> irqVector == rivm_pkg::SLOT_CNT1_CAPT)
    else $error("Counter 1 capture slot wrong");

  a_serial_slot: assert property ( // see R12
    @(posedge clk) disable iff (rst)
    clkEn && !vectorSelectBit && intEnable
    && reqBits[16:0] == 17'h10000
    |=> irqVector == rivm_pkg::SLOT_SERIAL)
    else $error("Serial transfer done slot wrong");

  a_async_rx_slot: assert property ( // see R13
    @(posedge clk) disable iff (rst)
    clkEn && !vectorSelectBit && intEnable
    && reqBits[17:0] == 18'h20000
    |=> irqVector == rivm_pkg::SLOT_ASYNC_RX)
    else $error("Async receive slot wrong");

  a_nvm_slot: assert property ( // see R14
    @(posedge clk) disable iff (rst)
    clkEn && !vectorSelectBit && intEnable
    && reqBits[21:0] == 22'h200000
    |=> irqVector == rivm_pkg::SLOT_NVM_READY)
    else $error("Data memory ready slot wrong");

  a_cause_holds_core: assert property ( // see R01
    @(posedge clk) disable iff (rst)
    clkEn && (|r.causeSync)
    |=> !coreRun)
    else $error("Core not held while a reset cause is active");

  a_take_only_run: assert property ( // see R15
    @(posedge clk) disable iff (rst)
    clkEn && r.st != rivm_pkg::ST_RUN
    |=> !fetchStrobe)
    else $error("Vector fetched outside the run state");

  a_disabled_quiet: assert property ( // see R16
    @(posedge clk) disable iff (rst)
    clkEn && !intEnable
    |=> !irqPending)
    else $error("Request pending while interrupts disabled");

  a_fetch_taken: assert property ( // see R15
    @(posedge clk) disable iff (rst)
    fetchStrobe |-> $past(takeIrq) && $past(irqPending)
    && fetchAddr == $past(irqVector) && !$past(fetchStrobe))
    else $error("Vector fetched without a taken interrupt");

  a_lowest_wins: assert property ( // see R16
    @(posedge clk) disable iff (rst)
    clkEn && intEnable && reqBits[0] && reqBits[24]
    |=> irqNumber == rivm_pkg::FIRST_VEC_NUM ##1 1'b1)
    else $error("Lowest vector number did not win");

endmodule

`default_nettype wire

// ===== rivm_pkg.sv
package rivm_pkg;

  localparam int          ADDR_W          = 12;
  localparam int          NUM_SRC         = 25;
  localparam int          NUM_CAUSE       = 4;
  localparam int          IDX_W           = 5;
  // Reset and table placement
  localparam logic [11:0] RESET_ADDR      = 12'h000;
  localparam logic [11:0] APP_BASE        = 12'h000;
  localparam logic [11:0] TABLE_OFS       = 12'h001;
  localparam logic [11:0] BOOT_START_DEF  = 12'hC00;
  localparam logic        FUSE_PROGRAMMED = 1'h0;
  localparam logic [4:0]  FIRST_VEC_NUM   = 5'h02;
  localparam logic [1:0]  HOLD_SETTLE     = 2'h3;
  // Slot addresses relative to the table base
  localparam logic [11:0] SLOT_EXT_ZERO   = 12'h001;
  localparam logic [11:0] SLOT_EXT_ONE    = 12'h002;
  localparam logic [11:0] SLOT_PIN_C      = 12'h005;
  localparam logic [11:0] SLOT_WATCHDOG   = 12'h006;
  localparam logic [11:0] SLOT_CNT2_OVF   = 12'h009;
  localparam logic [11:0] SLOT_CNT1_CAPT  = 12'h00A;
  localparam logic [11:0] SLOT_CNT1_OVF   = 12'h00D;
  localparam logic [11:0] SLOT_CNT0_OVF   = 12'h010;
  localparam logic [11:0] SLOT_SERIAL     = 12'h011;
  localparam logic [11:0] SLOT_ASYNC_RX   = 12'h012;
  localparam logic [11:0] SLOT_ASYNC_TXC  = 12'h014;
  localparam logic [11:0] SLOT_CONV_DONE  = 12'h015;
  localparam logic [11:0] SLOT_NVM_READY  = 12'h016;
  localparam logic [11:0] SLOT_STORE_RDY  = 12'h019;

  typedef enum logic [1:0] {
    ST_HOLD   = 2'h0,
    ST_LAUNCH = 2'h1,
    ST_RUN    = 2'h3,
    ST_TAKEN  = 2'h2
  } rivm_state_e;

  // Lowest bit is the highest-priority source
  typedef struct packed {
    logic storeProgramReadyReq;
    logic twoWireReq;
    logic analogComparatorReq;
    logic dataNvmReadyReq;
    logic analogConvDoneReq;
    logic asyncTxDoneReq;
    logic asyncTxEmptyReq;
    logic asyncRxDoneReq;
    logic serialPeriphDoneReq;
    logic counter0OverflowReq;
    logic counter0MatchBReq;
    logic counter0MatchAReq;
    logic counter1OverflowReq;
    logic counter1MatchBReq;
    logic counter1MatchAReq;
    logic counter1CaptureReq;
    logic counter2OverflowReq;
    logic counter2MatchBReq;
    logic counter2MatchAReq;
    logic watchdogTimeoutReq;
    logic pinChangeReqC;
    logic pinChangeReqB;
    logic pinChangeReqA;
    logic extRequestOne;
    logic extRequestZero;
  } rivm_req_s;

  typedef struct packed {
    logic watchdogSysReset;
    logic brownOutReset;
    logic powerOnReset;
    logic extPinReset;
  } rivm_cause_s;

  typedef struct packed {
    rivm_state_e st;
    logic [1:0]  holdCnt;
    logic [3:0]  causeMeta;
    logic [3:0]  causeSync;
    logic        fuseMeta;
    logic        fuseSync;
    logic        fuseProg;
    logic        coreRun;
    logic        resetFetch;
    logic [11:0] resetAddr;
    logic        irqPending;
    logic [11:0] irqVector;
    logic [4:0]  irqNumber;
    logic        fetchStrobe;
    logic [11:0] fetchAddr;
  } rivm_regs_s;

endpackage

// ===== rivm_prio_enc.sv
`timescale 1ns/1ps
`default_nettype none

module rivm_prio_enc #(
  parameter int N  = 25,
  parameter int IW = 5
) (
  // Requests, bit 0 wins
  input  wire logic [N-1:0]  req,
  // Winner
  output logic               found,
  output logic [IW-1:0]      idx
);

  logic [N:0]   below;
  logic [N-1:0] grant;

  assign below[0] = 1'b0;

  for (genvar i = 0; i < N; i++) begin : g_bit
    assign grant[i]    = req[i] & ~below[i];
    assign below[i+1]  = below[i] | req[i];
  end

  assign found = below[N];

  // Grant is one-hot, so OR-ing indices is exact
  always_comb begin
    idx = '0;
    for (int j = 0; j < N; j++) begin
      if (grant[j]) begin
        idx = idx | IW'(j);
      end
    end
  end

endmodule

`default_nettype wire
